//--- csef_pkg.sv
// Package: register map, field positions, reset values and carrier types of the clock status block
package csef_pkg;

   localparam logic [7:0] ADDR_STATUS = 8'h2C;
   localparam logic [7:0] ADDR_FLAGS = 8'h30;
   localparam logic [7:0] ADDR_SET = 8'h34;
   localparam logic [7:0] ADDR_CLEAR = 8'h38;

   localparam int FLAG_W = 7;
   localparam int STAT_W = 15;

   // Event flag positions
   localparam int EV_HI_RC = 0;
   localparam int EV_HI_XTAL = 1;
   localparam int EV_LO_RC = 2;
   localparam int EV_LO_XTAL = 3;
   localparam int EV_AUX_RC = 4;
   localparam int EV_CAL_DONE = 5;
   localparam int EV_CAL_OVF = 6;

   // Status bit positions
   localparam int ST_HI_RC_ON = 0;
   localparam int ST_HI_RC_RDY = 1;
   localparam int ST_HI_XTAL_ON = 2;
   localparam int ST_HI_XTAL_RDY = 3;
   localparam int ST_AUX_RC_ON = 4;
   localparam int ST_AUX_RC_RDY = 5;
   localparam int ST_LO_RC_ON = 6;
   localparam int ST_LO_RC_RDY = 7;
   localparam int ST_LO_XTAL_ON = 8;
   localparam int ST_LO_XTAL_RDY = 9;
   localparam int ST_SEL_LSB = 10;
   localparam int ST_CAL_RUNNING = 14;

   localparam logic [FLAG_W-1:0] FLAGS_RESET = 7'h01;
   localparam logic [STAT_W-1:0] STATUS_RESET = 15'h0403;
   localparam logic [4:0] OSC_ON_RESET = 5'h01;

   // One-hot source of the main high clock: bit 0 high RC .. bit 3 low crystal
   localparam logic [3:0] SEL_HI_RC = 4'h1;
   localparam logic [3:0] SEL_HI_XTAL = 4'h2;
   localparam logic [3:0] SEL_LO_RC = 4'h4;
   localparam logic [3:0] SEL_LO_XTAL = 4'h8;

   // Start-up time for each oscillator, in ns; counts derived at 50 MHz
   localparam int CLK_NS = 20;
   localparam int STARTUP_NS = 2000;
   localparam int STARTUP_CYC = (STARTUP_NS + CLK_NS - 1) / CLK_NS;
   localparam int CNT_W = 8;

   // Oscillator order in the five-wide vectors follows the event flag bits
   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } csef_bus_req_t;

   typedef struct packed {
      logic cal_start;
      logic cal_stop;
      logic cal_wrap;
   } csef_cal_in_t;

endpackage : csef_pkg

//--- csef_osc_startup.sv
// One oscillator's enable tracking and start-up timer
`timescale 1ns/1ps
module csef_osc_startup #(
   parameter logic ON_RESET = 1'b0
) (
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic i_enable,
   output logic o_on,
   output logic o_ready,
   output logic o_ready_pulse
);
   typedef struct packed {
      logic on;
      logic rdy;
      logic pulse;
      logic [csef_pkg::CNT_W-1:0] cnt;
   } csef_osc_state_t;

   localparam logic [csef_pkg::CNT_W-1:0] LAST = csef_pkg::CNT_W'(csef_pkg::STARTUP_CYC - 1);

   csef_osc_state_t s_q;
   csef_osc_state_t s_d;

   always_comb begin
      s_d = s_q;
      s_d.pulse = 1'b0;
      s_d.on = i_enable;
      if (!i_enable) begin
         s_d.rdy = 1'b0;
         s_d.cnt = '0;
      end else if (s_q.on && !s_q.rdy) begin
         // Ready only once enabled and the start-up time has run out
         if (s_q.cnt == LAST) begin
            s_d.rdy = 1'b1;
            s_d.pulse = 1'b1;
         end else begin
            s_d.cnt = s_q.cnt + 1'b1;
         end
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         s_q <= '{on: ON_RESET, rdy: ON_RESET, pulse: 1'b0, cnt: '0};
      end else begin
         s_q <= s_d;
      end
   end

   assign o_on = s_q.on;
   assign o_ready = s_q.rdy;
   assign o_ready_pulse = s_q.pulse;

   rdy_needs_on_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      o_ready |-> o_on) else $error("ready without enable");
   rdy_timing_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      $rose(o_ready) |-> $past(o_on, csef_pkg::STARTUP_CYC))
      else $error("ready before start-up time");
endmodule : csef_osc_startup

//--- csef_cal_track.sv
// Calibration busy tracking with done and overflow event pulses
`timescale 1ns/1ps
module csef_cal_track (
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire csef_pkg::csef_cal_in_t i_cal,
   output logic o_running,
   output logic o_done_pulse,
   output logic o_ovf_pulse
);
   typedef enum logic [0:0] {
      CAL_IDLE = 1'b0,
      CAL_BUSY = 1'b1
   } csef_cal_st_t;

   typedef struct packed {
      csef_cal_st_t st;
      logic done;
      logic ovf;
   } csef_cal_state_t;

   csef_cal_state_t s_q;
   csef_cal_state_t s_d;

   always_comb begin
      s_d = s_q;
      s_d.done = 1'b0;
      s_d.ovf = i_cal.cal_wrap;
      case (s_q.st)
         CAL_IDLE: begin
            if (i_cal.cal_start) begin
               s_d.st = CAL_BUSY;
            end
         end
         CAL_BUSY: begin
            if (i_cal.cal_stop) begin
               s_d.st = CAL_IDLE;
               s_d.done = 1'b1;
            end
         end
         default: begin
            s_d.st = CAL_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         s_q <= '{st: CAL_IDLE, done: 1'b0, ovf: 1'b0};
      end else begin
         s_q <= s_d;
      end
   end

   assign o_running = (s_q.st == CAL_BUSY);
   assign o_done_pulse = s_q.done;
   assign o_ovf_pulse = s_q.ovf;

   done_after_busy_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      o_done_pulse |-> $past(o_running) && !o_running) else $error("done not at end of busy");
endmodule : csef_cal_track

//--- csef_top.sv
// Clock status word and sticky clock event flags with their register port
`timescale 1ns/1ps
module csef_top (
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire csef_pkg::csef_bus_req_t i_bus,
   output logic [31:0] o_rdata,
   input wire logic [4:0] i_osc_enable,
   input wire logic [3:0] i_main_clk_sel,
   input wire csef_pkg::csef_cal_in_t i_cal
);
   typedef struct packed {
      logic [csef_pkg::FLAG_W-1:0] flags;
      logic [3:0] sel;
      logic [31:0] rdata;
   } csef_top_state_t;

   csef_top_state_t s_q;
   csef_top_state_t s_d;

   logic [4:0] osc_on;
   logic [4:0] osc_rdy;
   logic [4:0] osc_pulse;
   logic cal_running;
   logic cal_done;
   logic cal_overflow;
   logic [csef_pkg::FLAG_W-1:0] hw_set;
   logic [csef_pkg::FLAG_W-1:0] sw_set;
   logic [csef_pkg::FLAG_W-1:0] sw_clr;
   logic [csef_pkg::STAT_W-1:0] status;

   ////////////////////////////////////////////////////////////////////////////////
   // Oscillators, index order as event flag bits

   for (genvar g = 0; g < 5; g++) begin : g_osc
      csef_osc_startup #(
         .ON_RESET(csef_pkg::OSC_ON_RESET[g])
      ) u_osc (
         .i_clk_sys(i_clk_sys),
         .i_rst(i_rst),
         .i_enable(i_osc_enable[g]),
         .o_on(osc_on[g]),
         .o_ready(osc_rdy[g]),
         .o_ready_pulse(osc_pulse[g])
      );
   end

   csef_cal_track u_cal (
      .i_clk_sys(i_clk_sys),
      .i_rst(i_rst),
      .i_cal(i_cal),
      .o_running(cal_running),
      .o_done_pulse(cal_done),
      .o_ovf_pulse(cal_overflow)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Status word

   always_comb begin
      status = '0;
      status[csef_pkg::ST_HI_RC_ON] = osc_on[csef_pkg::EV_HI_RC];
      status[csef_pkg::ST_HI_RC_RDY] = osc_rdy[csef_pkg::EV_HI_RC];
      status[csef_pkg::ST_HI_XTAL_ON] = osc_on[csef_pkg::EV_HI_XTAL];
      status[csef_pkg::ST_HI_XTAL_RDY] = osc_rdy[csef_pkg::EV_HI_XTAL];
      status[csef_pkg::ST_AUX_RC_ON] = osc_on[csef_pkg::EV_AUX_RC];
      status[csef_pkg::ST_AUX_RC_RDY] = osc_rdy[csef_pkg::EV_AUX_RC];
      status[csef_pkg::ST_LO_RC_ON] = osc_on[csef_pkg::EV_LO_RC];
      status[csef_pkg::ST_LO_RC_RDY] = osc_rdy[csef_pkg::EV_LO_RC];
      status[csef_pkg::ST_LO_XTAL_ON] = osc_on[csef_pkg::EV_LO_XTAL];
      status[csef_pkg::ST_LO_XTAL_RDY] = osc_rdy[csef_pkg::EV_LO_XTAL];
      status[csef_pkg::ST_SEL_LSB +: 4] = s_q.sel;
      status[csef_pkg::ST_CAL_RUNNING] = cal_running;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Event flags and register port

   always_comb begin
      hw_set = {cal_overflow, cal_done, osc_pulse};
      sw_set = '0;
      sw_clr = '0;
      // Only the low flag bits are decoded; reserved write bits are dropped
      if (i_bus.wr && i_bus.addr == csef_pkg::ADDR_SET) begin
         sw_set = i_bus.wdata[csef_pkg::FLAG_W-1:0];
      end
      if (i_bus.wr && i_bus.addr == csef_pkg::ADDR_CLEAR) begin
         sw_clr = i_bus.wdata[csef_pkg::FLAG_W-1:0];
      end
   end

   always_comb begin
      s_d = s_q;
      // A hardware event in the clearing cycle survives: set wins over clear
      s_d.flags = (s_q.flags & ~sw_clr) | sw_set | hw_set;
      // Illegal or empty select keeps the last legal source so one bit stays high
      case (i_main_clk_sel)
         csef_pkg::SEL_HI_RC,
         csef_pkg::SEL_HI_XTAL,
         csef_pkg::SEL_LO_RC,
         csef_pkg::SEL_LO_XTAL: begin
            s_d.sel = i_main_clk_sel;
         end
         default: begin
            s_d.sel = s_q.sel;
         end
      endcase
      s_d.rdata = '0;
      if (i_bus.rd) begin
         case (i_bus.addr)
            csef_pkg::ADDR_STATUS: begin
               s_d.rdata = 32'(status);
            end
            csef_pkg::ADDR_FLAGS: begin
               s_d.rdata = 32'(s_q.flags);
            end
            default: begin
               s_d.rdata = '0;
            end
         endcase
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         s_q <= '{flags: csef_pkg::FLAGS_RESET, sel: csef_pkg::SEL_HI_RC, rdata: '0};
      end else begin
         s_q <= s_d;
      end
   end

   assign o_rdata = s_q.rdata;

   ////////////////////////////////////////////////////////////////////////////////
   // Checks

   sel_onehot_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      $onehot(status[csef_pkg::ST_SEL_LSB +: 4])) else $error("select not one-hot");
   reset_status_a: assert property (@(posedge i_clk_sys)
      $past(i_rst) |-> s_q.flags == csef_pkg::FLAGS_RESET && s_q.sel == csef_pkg::SEL_HI_RC)
      else $error("bad reset values");
   ready_flag_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      $rose(osc_rdy[csef_pkg::EV_LO_XTAL]) |=> s_q.flags[csef_pkg::EV_LO_XTAL])
      else $error("ready flag missing");
   cal_done_flag_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      $fell(cal_running) |=> s_q.flags[csef_pkg::EV_CAL_DONE])
      else $error("calibration done flag missing");
   cal_ovf_flag_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      i_cal.cal_wrap |=> ##1 s_q.flags[csef_pkg::EV_CAL_OVF])
      else $error("overflow flag missing");
   flag_set_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      i_bus.wr && i_bus.addr == csef_pkg::ADDR_SET |=>
      (s_q.flags & $past(i_bus.wdata[csef_pkg::FLAG_W-1:0]))
      == $past(i_bus.wdata[csef_pkg::FLAG_W-1:0]))
      else $error("set write lost");
   flag_clear_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      i_bus.wr && i_bus.addr == csef_pkg::ADDR_CLEAR && !(|hw_set) |=>
      (s_q.flags & $past(i_bus.wdata[csef_pkg::FLAG_W-1:0])) == '0)
      else $error("clear write lost");
   flag_sticky_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      !(i_bus.wr && i_bus.addr == csef_pkg::ADDR_CLEAR) |=>
      (s_q.flags & $past(s_q.flags)) == $past(s_q.flags))
      else $error("flag dropped without clear");
   status_read_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      i_bus.rd && i_bus.addr == csef_pkg::ADDR_STATUS |=> o_rdata == 32'($past(status)))
      else $error("status read wrong");
endmodule : csef_top

//--- csef_bench.sv
// Self-checking bench for the clock status word and sticky event flags
`timescale 1ns/1ps
module csef_bench;
   typedef struct packed {
      logic [4:0] en;
      logic [3:0] sel;
      logic [31:0] status;
      logic [31:0] flags;
   } csef_row_t;

   logic i_clk_sys;
   logic i_rst;
   csef_pkg::csef_bus_req_t i_bus;
   logic [31:0] o_rdata;
   logic [4:0] i_osc_enable;
   logic [3:0] i_main_clk_sel;
   csef_pkg::csef_cal_in_t i_cal;
   int miscompares;
   int check_count;
   int cycles = 0;
   csef_row_t rows [8];

   csef_top csef_top_i (
      .i_clk_sys(i_clk_sys),
      .i_rst(i_rst),
      .i_bus(i_bus),
      .o_rdata(o_rdata),
      .i_osc_enable(i_osc_enable),
      .i_main_clk_sel(i_main_clk_sel),
      .i_cal(i_cal)
   );

   initial begin
      i_clk_sys = 1'b0;
      forever #10 i_clk_sys = ~i_clk_sys;
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic print_verdict();
      $display("checks %0d, mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : print_verdict

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic tick(input int n);
      repeat (n) @(posedge i_clk_sys);
   endtask : tick

   // Only the low flag bits are ever written; reserved bits stay zero
   task automatic wr(input logic [7:0] addr, input logic [31:0] data);
      @(posedge i_clk_sys);
      i_bus.addr <= addr;
      i_bus.wdata <= data;
      i_bus.wr <= 1'b1;
      @(posedge i_clk_sys);
      i_bus.wr <= 1'b0;
   endtask : wr

   // Read data stand only in the cycle after the strobe, so sample just after that edge
   task automatic rd(input string name, input logic [7:0] addr, input logic [31:0] exp);
      @(posedge i_clk_sys);
      i_bus.addr <= addr;
      i_bus.rd <= 1'b1;
      @(posedge i_clk_sys);
      i_bus.rd <= 1'b0;
      #1;
      check(name, o_rdata, exp);
   endtask : rd

   task automatic pulse_cal(input int which);
      @(posedge i_clk_sys);
      i_cal <= (which == 0) ? 3'h4 : (which == 1) ? 3'h2 : 3'h1;
      @(posedge i_clk_sys);
      i_cal <= 3'h0;
   endtask : pulse_cal

   task automatic do_reset();
      @(posedge i_clk_sys);
      i_rst <= 1'b1;
      tick(20);
      i_rst <= 1'b0;
   endtask : do_reset

   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge i_clk_sys) begin
      cycles <= cycles + 1;
      // Roughly four times the expected run length
      if (cycles == 5000) begin
         miscompares++;
         print_verdict();
      end
   end

   initial begin
      i_rst = 1'b1;
      i_bus = '0;
      i_osc_enable = 5'h01;
      i_main_clk_sel = 4'h1;
      i_cal = '0;
      miscompares = 0;
      check_count = 0;
      // Rows 0 to 4 enable more sources, rows 5 to 7 fewer; ready flags accumulate and stay
      rows[0] = {5'h01, 4'h1, 32'h00000403, 32'h00000001};
      rows[1] = {5'h03, 4'h2, 32'h0000080F, 32'h00000003};
      rows[2] = {5'h07, 4'h4, 32'h000010CF, 32'h00000007};
      rows[3] = {5'h0F, 4'h8, 32'h000023CF, 32'h0000000F};
      rows[4] = {5'h1F, 4'h1, 32'h000007FF, 32'h0000001F};
      rows[5] = {5'h01, 4'h3, 32'h00000403, 32'h0000001F};
      rows[6] = {5'h10, 4'h2, 32'h00000830, 32'h0000001F};
      rows[7] = {5'h01, 4'h1, 32'h00000403, 32'h0000001F};
      tick(20);
      i_rst <= 1'b0;
      rd("status after reset", 8'h2C, 32'h00000403);
      rd("flags after reset", 8'h30, 32'h00000001);
      foreach (rows[i]) begin
         @(posedge i_clk_sys);
         i_osc_enable <= rows[i].en;
         i_main_clk_sel <= rows[i].sel;
         tick(120);
         rd("row status", 8'h2C, rows[i].status);
         rd("row flags", 8'h30, rows[i].flags);
      end
      // Writes to the read-only words must change nothing
      wr(8'h30, 32'h00000000);
      wr(8'h2C, 32'h00000000);
      rd("flags after ro write", 8'h30, 32'h0000001F);
      rd("status after ro write", 8'h2C, 32'h00000403);
      wr(8'h38, 32'h00000001);
      rd("flags clear one", 8'h30, 32'h0000001E);
      wr(8'h38, 32'h0000007E);
      rd("flags clear rest", 8'h30, 32'h00000000);
      wr(8'h34, 32'h00000041);
      wr(8'h34, 32'h00000000);
      rd("flags set", 8'h30, 32'h00000041);
      rd("unmapped read", 8'h3C, 32'h00000000);
      wr(8'h38, 32'h0000007F);
      pulse_cal(0);
      rd("cal busy", 8'h2C, 32'h00004403);
      pulse_cal(1);
      tick(3);
      rd("cal done flag", 8'h30, 32'h00000020);
      rd("cal idle", 8'h2C, 32'h00000403);
      pulse_cal(2);
      tick(3);
      rd("cal overflow flag", 8'h30, 32'h00000060);
      // Clear strobe meets the overflow event in one cycle: the event must win
      pulse_cal(2);
      i_bus.addr <= 8'h38;
      i_bus.wdata <= 32'h00000040;
      i_bus.wr <= 1'b1;
      @(posedge i_clk_sys);
      i_bus.wr <= 1'b0;
      rd("set beats clear", 8'h30, 32'h00000060);
      // Ready must wait for the full start-up time
      @(posedge i_clk_sys);
      i_osc_enable <= 5'h03;
      tick(50);
      rd("crystal starting", 8'h2C, 32'h00000407);
      tick(60);
      rd("crystal ready", 8'h2C, 32'h0000040F);
      rd("crystal flag", 8'h30, 32'h00000062);
      @(posedge i_clk_sys);
      i_osc_enable <= 5'h01;
      do_reset();
      rd("status second reset", 8'h2C, 32'h00000403);
      rd("flags second reset", 8'h30, 32'h00000001);
      print_verdict();
   end
endmodule : csef_bench
